/* File: pkg/tmw_pkg.sv */
// Shared constants and types of the timer block: register map,
// control field layouts, reset values and interrupt bit positions.
// Assumes a 32-bit APB slave decoding the low eight address bits.
package tmw_pkg;

	localparam int NUM_GP = 3;
	localparam int NUM_WD = 2;
	localparam int GP_W = 32;
	localparam int WD_W = 32;
	localparam int OS_W = 24;

	// Byte addresses of the register map
	localparam logic [7:0] IRQ_STATUS = 8'h00;
	localparam logic [7:0] IRQ_MASK = 8'h04;
	localparam logic [7:0] OS_CTRL = 8'h08;
	localparam logic [7:0] OS_RELOAD = 8'h0c;
	localparam logic [7:0] OS_COUNT = 8'h10;
	localparam logic [7:0] GP_BASE = 8'h20;
	localparam logic [7:0] GP_STRIDE = 8'h10;
	localparam logic [7:0] GP_CTRL_OFF = 8'h00;
	localparam logic [7:0] GP_RELOAD_OFF = 8'h04;
	localparam logic [7:0] GP_COUNT_OFF = 8'h08;
	localparam logic [7:0] WD_BASE = 8'h60;
	localparam logic [7:0] WD_STRIDE = 8'h10;
	localparam logic [7:0] WD_CTRL_OFF = 8'h00;
	localparam logic [7:0] WD_LOAD_OFF = 8'h04;
	localparam logic [7:0] WD_TIMEOUT_OFF = 8'h08;
	localparam logic [7:0] WD_RESTART_OFF = 8'h0c;

	// Interrupt status and mask bit positions
	localparam int IRQ_W = 6;
	localparam int IRQ_GP_LSB = 0;
	localparam int IRQ_WD_LSB = 3;
	localparam int IRQ_OS_BIT = 5;

	// Counting source select codes
	localparam logic [1:0] SRC_RC_MAIN = 2'h0;
	localparam logic [1:0] SRC_RC_BACKUP = 2'h1;
	localparam logic [1:0] SRC_XOSC = 2'h2;
	localparam logic [1:0] SRC_PLL = 2'h3;

	// External input use of a general-purpose timer
	typedef enum logic [1:0] {
		TMW_EXT_OFF = 2'h0,
		TMW_EXT_CLOCK = 2'h1,
		TMW_EXT_GATE = 2'h2
	} tmw_ext_mode_type;

	typedef struct packed {
		tmw_ext_mode_type ext_mode;
		logic [1:0] clk_sel;
		logic sync_en;
		logic soc_en;
		logic irq_en;
		logic enable;
	} tmw_gp_ctrl_type;

	typedef struct packed {
		logic [1:0] clk_sel;
		logic dbg_freeze;
		logic reset_mode;
		logic enable;
	} tmw_wd_ctrl_type;

	// Reset values
	localparam tmw_gp_ctrl_type GP_CTRL_RST = '{TMW_EXT_OFF, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0};
	localparam tmw_wd_ctrl_type WD_CTRL_RST = '{2'h0, 1'b0, 1'b0, 1'b0};
	localparam logic [GP_W-1:0] GP_RELOAD_RST = 32'h0000_0000;
	localparam logic [WD_W-1:0] WD_LOAD_RST = 32'hffff_ffff;
	localparam logic [WD_W-1:0] WD_TIMEOUT_RST = 32'h0000_0000;
	localparam logic [OS_W-1:0] OS_RELOAD_RST = 24'h00_0000;
	localparam logic [IRQ_W-1:0] IRQ_RST = 6'h00;

endpackage

/* File: src/tmw_tick_sel.sv */
// Count-enable selector of one timer: picks a source tick and applies
// the external input as clock (rising edge) or as a gate.
// Assumes all source ticks and the external input are pclk-synchronous.
`timescale 1ns/10ps
module tmw_tick_sel (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] src_tick,
	input wire logic [1:0] clk_sel,
	input wire tmw_pkg::tmw_ext_mode_type ext_mode,
	input wire logic ext_in,
	output logic count_en
);
	logic ext_q;
	logic next_ext_q;
	logic src_en;

	// Previous external level for edge detection
	always_comb begin
		next_ext_q = ext_in;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_q <= 1'b0;
		end else begin
			ext_q <= next_ext_q;
		end
	end

	// Source mux, then external input as clock or gate
	always_comb begin
		src_en = src_tick[clk_sel];
		case (ext_mode)
			tmw_pkg::TMW_EXT_CLOCK: count_en = ext_in & ~ext_q;
			tmw_pkg::TMW_EXT_GATE: count_en = src_en & ext_in;
			default: count_en = src_en;
		endcase
	end

	property p_gate_blocks;
		@(posedge pclk) disable iff (!presetn)
		ext_mode == tmw_pkg::TMW_EXT_GATE && !ext_in |-> !count_en;
	endproperty
	a_gate_blocks: assert property (p_gate_blocks)
		else $error("gated timer counted with gate low");

	property p_src_select;
		@(posedge pclk) disable iff (!presetn)
		ext_mode == tmw_pkg::TMW_EXT_OFF |-> count_en == src_tick[clk_sel];
	endproperty
	a_src_select: assert property (p_src_select)
		else $error("count enable does not follow selected source");

endmodule // tmw_tick_sel

/* File: src/tmw_down_counter.sv */
// Loadable down-counter with optional auto-reload one cycle after zero.
// Assumes load and count_en are one-cycle requests in the pclk domain.
`timescale 1ns/10ps
module tmw_down_counter #(
	parameter int W = 32,
	parameter bit AUTO = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enable,
	input wire logic count_en,
	input wire logic load,
	input wire logic [W-1:0] load_value,
	output logic [W-1:0] count,
	output logic zero_evt
);
	localparam logic [W-1:0] ONE = W'(1);

	logic [W-1:0] next_count;
	logic next_zero;

	// Load wins over reload and step; zero is flagged as it is reached
	always_comb begin
		next_count = count;
		next_zero = 1'b0;
		if (load) begin
			next_count = load_value;
		end else if (enable) begin
			if (AUTO && count == '0) begin
				next_count = load_value;
			end else if (count_en && count != '0) begin
				next_count = count - ONE;
				next_zero = (count == ONE);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
			zero_evt <= 1'b0;
		end else begin
			count <= next_count;
			zero_evt <= next_zero;
		end
	end

	property p_reload;
		@(posedge pclk) disable iff (!presetn)
		AUTO && enable && !load && count == '0 |=> count == $past(load_value);
	endproperty
	a_reload: assert property (p_reload)
		else $error("counter did not reload after zero");

	property p_step;
		@(posedge pclk) disable iff (!presetn)
		enable && count_en && !load && count != '0
		|=> count == $past(count) - ONE && zero_evt == ($past(count) == ONE);
	endproperty
	a_step: assert property (p_step)
		else $error("counter step or zero event wrong");

endmodule // tmw_down_counter

/* File: src/tmw_timers.sv */
// Timer subsystem: three general-purpose timers, two watchdogs and the
// OS tick timer behind an APB slave with one interrupt output.
// Assumes a single pclk domain; source ticks are pclk-synchronous pulses.
//
// Notes on behaviour
// - three identical 32-bit auto-reload down-counting general-purpose timers.
// - timer zero sets its interrupt flag only while its interrupt enable is set.
// - timer zero pulses ADC trigger and PWM sync, each behind own enable.
// - timer counting source selectable among RC, backup RC, crystal, PLL.
// - external input optionally serves as counting clock or counting gate.
// - two identical 32-bit watchdog down-counters with selectable counting source.
// - watchdog reaching time-out raises interrupt or reset as configured.
// - in debug halt each watchdog freezes or runs, per its setting.
// - OS tick timer is a 24-bit auto-reload down-counter.
// - OS tick zero sets a maskable interrupt flag.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
module tmw_timers (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] src_tick,
	input wire logic [2:0] ext_in,
	input wire logic debug_halt,
	output logic irq,
	output logic [2:0] adc_conversion_trigger,
	output logic [2:0] pwm_sync_event,
	output logic wd_reset_req
);
	localparam int NG = tmw_pkg::NUM_GP;
	localparam int NW = tmw_pkg::NUM_WD;

	tmw_pkg::tmw_gp_ctrl_type gp_ctrl [NG];
	tmw_pkg::tmw_gp_ctrl_type next_gp_ctrl [NG];
	logic [31:0] gp_reload [NG];
	logic [31:0] next_gp_reload [NG];
	logic [31:0] gp_count [NG];
	logic [NG-1:0] gp_load;
	logic [NG-1:0] gp_cen;
	logic [NG-1:0] gp_zero;
	tmw_pkg::tmw_wd_ctrl_type wd_ctrl [NW];
	tmw_pkg::tmw_wd_ctrl_type next_wd_ctrl [NW];
	logic [31:0] wd_load [NW];
	logic [31:0] next_wd_load [NW];
	logic [31:0] wd_timeout [NW];
	logic [31:0] next_wd_timeout [NW];
	logic [31:0] wd_count [NW];
	logic [NW-1:0] wd_expired;
	logic [NW-1:0] next_wd_expired;
	logic [NW-1:0] wd_restart;
	logic [NW-1:0] wd_src;
	logic [NW-1:0] wd_run;
	logic [NW-1:0] wd_hit;
	logic next_wd_reset_req;
	logic os_enable;
	logic next_os_enable;
	logic [23:0] os_reload;
	logic [23:0] next_os_reload;
	logic [23:0] os_count;
	logic os_load;
	logic os_zero;
	logic [5:0] irq_status;
	logic [5:0] next_irq_status;
	logic [5:0] irq_mask;
	logic [5:0] next_irq_mask;
	logic [5:0] irq_set;
	logic [2:0] next_adc;
	logic [2:0] next_sync;
	logic [31:0] rdata;
	logic hit;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic wr_en;

	// Address of a register inside a repeated bank
	function automatic logic [7:0] bank_addr(logic [7:0] base, logic [7:0] stride,
			int idx, logic [7:0] off);
		return 8'(base + 8'(stride * idx) + off);
	endfunction

	// Zero-wait slave; a write lands in the access cycle
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;

	// General-purpose timers
	for (genvar g = 0; g < NG; g++) begin : g_gp
		tmw_tick_sel u_sel (
			.pclk(pclk),
			.presetn(presetn),
			.src_tick(src_tick),
			.clk_sel(gp_ctrl[g].clk_sel),
			.ext_mode(gp_ctrl[g].ext_mode),
			.ext_in(ext_in[g]),
			.count_en(gp_cen[g])
		);
		tmw_down_counter #(.W(tmw_pkg::GP_W), .AUTO(1'b1)) u_cnt (
			.pclk(pclk),
			.presetn(presetn),
			.enable(gp_ctrl[g].enable),
			.count_en(gp_cen[g]),
			.load(gp_load[g]),
			.load_value(gp_reload[g]),
			.count(gp_count[g]),
			.zero_evt(gp_zero[g])
		);
	end

	// Watchdogs: no reload, counting halts at the time-out value
	for (genvar w = 0; w < NW; w++) begin : g_wd
		tmw_tick_sel u_sel (
			.pclk(pclk),
			.presetn(presetn),
			.src_tick(src_tick),
			.clk_sel(wd_ctrl[w].clk_sel),
			.ext_mode(tmw_pkg::TMW_EXT_OFF),
			.ext_in(1'b0),
			.count_en(wd_src[w])
		);
		// Freeze only matters while the core sits in debug halt
		assign wd_run[w] = wd_src[w] & ~(debug_halt & wd_ctrl[w].dbg_freeze)
			& ~wd_expired[w] & (wd_count[w] != wd_timeout[w]);
		assign wd_hit[w] = wd_ctrl[w].enable & ~wd_expired[w] & ~wd_restart[w]
			& (wd_count[w] == wd_timeout[w]);
		tmw_down_counter #(.W(tmw_pkg::WD_W), .AUTO(1'b0)) u_cnt (
			.pclk(pclk),
			.presetn(presetn),
			.enable(wd_ctrl[w].enable),
			.count_en(wd_run[w]),
			.load(wd_restart[w]),
			.load_value(wd_load[w]),
			.count(wd_count[w]),
			.zero_evt()
		);
	end

	// OS tick counts every pclk
	tmw_down_counter #(.W(tmw_pkg::OS_W), .AUTO(1'b1)) u_os (
		.pclk(pclk),
		.presetn(presetn),
		.enable(os_enable),
		.count_en(1'b1),
		.load(os_load),
		.load_value(os_reload),
		.count(os_count),
		.zero_evt(os_zero)
	);

	// Read mux and address decode
	always_comb begin
		rdata = 32'h0000_0000;
		hit = 1'b1;
		case (paddr)
			tmw_pkg::IRQ_STATUS: rdata = 32'(irq_status);
			tmw_pkg::IRQ_MASK: rdata = 32'(irq_mask);
			tmw_pkg::OS_CTRL: rdata = 32'(os_enable);
			tmw_pkg::OS_RELOAD: rdata = 32'(os_reload);
			tmw_pkg::OS_COUNT: rdata = 32'(os_count);
			default: hit = 1'b0;
		endcase
		for (int i = 0; i < NG; i++) begin
			if (paddr == bank_addr(tmw_pkg::GP_BASE, tmw_pkg::GP_STRIDE, i,
					tmw_pkg::GP_CTRL_OFF)) begin
				rdata = 32'(gp_ctrl[i]);
				hit = 1'b1;
			end
			if (paddr == bank_addr(tmw_pkg::GP_BASE, tmw_pkg::GP_STRIDE, i,
					tmw_pkg::GP_RELOAD_OFF)) begin
				rdata = gp_reload[i];
				hit = 1'b1;
			end
			if (paddr == bank_addr(tmw_pkg::GP_BASE, tmw_pkg::GP_STRIDE, i,
					tmw_pkg::GP_COUNT_OFF)) begin
				rdata = gp_count[i];
				hit = 1'b1;
			end
		end
		for (int i = 0; i < NW; i++) begin
			if (paddr == bank_addr(tmw_pkg::WD_BASE, tmw_pkg::WD_STRIDE, i,
					tmw_pkg::WD_CTRL_OFF)) begin
				rdata = 32'(wd_ctrl[i]);
				hit = 1'b1;
			end
			if (paddr == bank_addr(tmw_pkg::WD_BASE, tmw_pkg::WD_STRIDE, i,
					tmw_pkg::WD_LOAD_OFF)) begin
				rdata = wd_load[i];
				hit = 1'b1;
			end
			if (paddr == bank_addr(tmw_pkg::WD_BASE, tmw_pkg::WD_STRIDE, i,
					tmw_pkg::WD_TIMEOUT_OFF)) begin
				rdata = wd_timeout[i];
				hit = 1'b1;
			end
			if (paddr == bank_addr(tmw_pkg::WD_BASE, tmw_pkg::WD_STRIDE, i,
					tmw_pkg::WD_RESTART_OFF)) begin
				rdata = wd_count[i];
				hit = 1'b1;
			end
		end
	end

	// Register writes, event flags and outputs; hardware set beats W1C clear
	always_comb begin
		next_gp_ctrl = gp_ctrl;
		next_gp_reload = gp_reload;
		next_wd_ctrl = wd_ctrl;
		next_wd_load = wd_load;
		next_wd_timeout = wd_timeout;
		next_os_enable = os_enable;
		next_os_reload = os_reload;
		next_irq_mask = irq_mask;
		gp_load = '0;
		wd_restart = '0;
		os_load = 1'b0;
		irq_set = '0;
		for (int i = 0; i < NG; i++) begin
			irq_set[tmw_pkg::IRQ_GP_LSB + i] = gp_zero[i] & gp_ctrl[i].irq_en;
			next_adc[i] = gp_zero[i] & gp_ctrl[i].soc_en;
			next_sync[i] = gp_zero[i] & gp_ctrl[i].sync_en;
		end
		for (int i = 0; i < NW; i++) begin
			irq_set[tmw_pkg::IRQ_WD_LSB + i] = wd_hit[i] & ~wd_ctrl[i].reset_mode;
		end
		irq_set[tmw_pkg::IRQ_OS_BIT] = os_zero;
		next_irq_status = irq_status;
		if (wr_en && paddr == tmw_pkg::IRQ_STATUS) begin
			next_irq_status = irq_status & ~pwdata[5:0];
		end
		next_irq_status = next_irq_status | irq_set;
		if (wr_en) begin
			case (paddr)
				tmw_pkg::IRQ_MASK: next_irq_mask = pwdata[5:0];
				tmw_pkg::OS_CTRL: next_os_enable = pwdata[0];
				tmw_pkg::OS_RELOAD: next_os_reload = pwdata[23:0];
				tmw_pkg::OS_COUNT: os_load = 1'b1;
				default: ;
			endcase
			for (int i = 0; i < NG; i++) begin
				if (paddr == bank_addr(tmw_pkg::GP_BASE, tmw_pkg::GP_STRIDE, i,
						tmw_pkg::GP_CTRL_OFF)) begin
					next_gp_ctrl[i] = tmw_pkg::tmw_gp_ctrl_type'(pwdata[7:0]);
				end
				if (paddr == bank_addr(tmw_pkg::GP_BASE, tmw_pkg::GP_STRIDE, i,
						tmw_pkg::GP_RELOAD_OFF)) begin
					next_gp_reload[i] = pwdata;
				end
				if (paddr == bank_addr(tmw_pkg::GP_BASE, tmw_pkg::GP_STRIDE, i,
						tmw_pkg::GP_COUNT_OFF)) begin
					gp_load[i] = 1'b1;
				end
			end
			for (int i = 0; i < NW; i++) begin
				if (paddr == bank_addr(tmw_pkg::WD_BASE, tmw_pkg::WD_STRIDE, i,
						tmw_pkg::WD_CTRL_OFF)) begin
					next_wd_ctrl[i] = tmw_pkg::tmw_wd_ctrl_type'(pwdata[4:0]);
				end
				if (paddr == bank_addr(tmw_pkg::WD_BASE, tmw_pkg::WD_STRIDE, i,
						tmw_pkg::WD_LOAD_OFF)) begin
					next_wd_load[i] = pwdata;
				end
				if (paddr == bank_addr(tmw_pkg::WD_BASE, tmw_pkg::WD_STRIDE, i,
						tmw_pkg::WD_TIMEOUT_OFF)) begin
					next_wd_timeout[i] = pwdata;
				end
				if (paddr == bank_addr(tmw_pkg::WD_BASE, tmw_pkg::WD_STRIDE, i,
						tmw_pkg::WD_RESTART_OFF)) begin
					wd_restart[i] = 1'b1;
				end
			end
		end
		// Reset request holds until restart; a system reset clears it anyway
		next_wd_expired = (wd_expired | wd_hit) & ~wd_restart;
		next_wd_reset_req = wd_reset_req;
		// Clear first, so a time-out of the other dog in the same cycle still wins
		if (|wd_restart) begin
			next_wd_reset_req = 1'b0;
		end
		for (int i = 0; i < NW; i++) begin
			if (wd_hit[i] && wd_ctrl[i].reset_mode) begin
				next_wd_reset_req = 1'b1;
			end
		end
		// Read data captured in setup so that it leaves a flip-flop
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (psel && !penable) begin
			next_prdata = pwrite ? 32'h0000_0000 : rdata;
			next_pslverr = ~hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NG; i++) begin
				gp_ctrl[i] <= tmw_pkg::GP_CTRL_RST;
				gp_reload[i] <= tmw_pkg::GP_RELOAD_RST;
			end
			for (int i = 0; i < NW; i++) begin
				wd_ctrl[i] <= tmw_pkg::WD_CTRL_RST;
				wd_load[i] <= tmw_pkg::WD_LOAD_RST;
				wd_timeout[i] <= tmw_pkg::WD_TIMEOUT_RST;
			end
			wd_expired <= '0;
			wd_reset_req <= 1'b0;
			os_enable <= 1'b0;
			os_reload <= tmw_pkg::OS_RELOAD_RST;
			irq_status <= tmw_pkg::IRQ_RST;
			irq_mask <= tmw_pkg::IRQ_RST;
			adc_conversion_trigger <= '0;
			pwm_sync_event <= '0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			gp_ctrl <= next_gp_ctrl;
			gp_reload <= next_gp_reload;
			wd_ctrl <= next_wd_ctrl;
			wd_load <= next_wd_load;
			wd_timeout <= next_wd_timeout;
			wd_expired <= next_wd_expired;
			wd_reset_req <= next_wd_reset_req;
			os_enable <= next_os_enable;
			os_reload <= next_os_reload;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			adc_conversion_trigger <= next_adc;
			pwm_sync_event <= next_sync;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// One level interrupt for all unmasked flags
	assign irq = |(irq_status & irq_mask);

	for (genvar g = 0; g < NG; g++) begin : g_chk_gp
		property p_gp_irq;
			@(posedge pclk) disable iff (!presetn)
			gp_zero[g] |=> irq_status[g] == $past(gp_ctrl[g].irq_en | irq_status[g]);
		endproperty
		a_gp_irq: assert property (p_gp_irq)
			else $error("timer zero flag wrong for its enable");

		property p_gp_trig;
			@(posedge pclk) disable iff (!presetn)
			##1 adc_conversion_trigger[g] == $past(gp_zero[g] & gp_ctrl[g].soc_en)
				&& pwm_sync_event[g] == $past(gp_zero[g] & gp_ctrl[g].sync_en);
		endproperty
		a_gp_trig: assert property (p_gp_trig)
			else $error("trigger pulse does not follow timer zero");
	end

	for (genvar w = 0; w < NW; w++) begin : g_chk_wd
		property p_wd_timeout;
			@(posedge pclk) disable iff (!presetn)
			wd_hit[w] |=> (wd_ctrl[w].reset_mode ? wd_reset_req
				: irq_status[tmw_pkg::IRQ_WD_LSB + w]) && wd_expired[w];
		endproperty
		a_wd_timeout: assert property (p_wd_timeout)
			else $error("watchdog time-out action missing");

		property p_wd_freeze;
			@(posedge pclk) disable iff (!presetn)
			debug_halt && wd_ctrl[w].dbg_freeze && !wd_restart[w]
				|=> wd_count[w] == $past(wd_count[w]);
		endproperty
		a_wd_freeze: assert property (p_wd_freeze)
			else $error("watchdog moved while frozen in debug");

		property p_wd_hold;
			@(posedge pclk) disable iff (!presetn)
			wd_expired[w] && !wd_restart[w] |=> $stable(wd_count[w]);
		endproperty
		a_wd_hold: assert property (p_wd_hold)
			else $error("expired watchdog kept counting");
	end

	property p_os_irq;
		@(posedge pclk) disable iff (!presetn)
		os_zero |=> irq_status[tmw_pkg::IRQ_OS_BIT] ##0 (irq == |(irq_status & irq_mask));
	endproperty
	a_os_irq: assert property (p_os_irq)
		else $error("OS tick flag not set on zero");

	property p_os_reload;
		@(posedge pclk) disable iff (!presetn)
		os_zero && os_enable && !os_load |=> os_count == $past(os_reload);
	endproperty
	a_os_reload: assert property (p_os_reload)
		else $error("OS tick did not reload");

endmodule // tmw_timers

/* File: sim/tmw_timers_tb.sv */
// Self-checking bench of the timer block: APB register traffic, timer periods,
// trigger pulses, external clock and gate, OS tick and both watchdogs.
// Assumes the register map and field layouts of tmw_pkg; no other model.
`timescale 1ns/10ps
module tmw_timers_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] src_tick = 4'h0;
	logic [2:0] ext_in = 3'h0;
	logic debug_halt = 1'b0;
	logic irq;
	logic [2:0] adc;
	logic [2:0] sync;
	logic wd_reset_req;
	int fail_count = 0;
	int n_tests = 0;
	int cyc = 0;
	int adc_n[3] = '{0, 0, 0};
	int syn_n[3] = '{0, 0, 0};
	logic [32:0] exp_q[$];
	logic [31:0] r;
	logic [1:0] sel;

	tmw_timers i_tmw_timers (
		.pclk(pclk),
		.presetn(presetn),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.src_tick(src_tick),
		.ext_in(ext_in),
		.debug_halt(debug_halt),
		.irq(irq),
		.adc_conversion_trigger(adc),
		.pwm_sync_event(sync),
		.wd_reset_req(wd_reset_req)
	);

	// 20 MHz clock
	always #25 pclk = ~pclk;

	task automatic end_sim();
		if (exp_q.size() != 0) fail_count++;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Cycle count, pulse tallies and the hang limit
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		for (int i = 0; i < 3; i++) begin
			adc_n[i] <= adc_n[i] + int'(adc[i]);
			syn_n[i] <= syn_n[i] + int'(sync[i]);
		end
		if (cyc == 30000) begin
			fail_count++;
			end_sim();
		end
	end

	// Read results are judged as they complete, oldest note first
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			if (exp_q.size() == 0) begin
				chk(32'hdead_0000, 32'h0);
			end else begin
				chk({31'h0, pslverr}, {31'h0, exp_q[0][32]});
				chk(prdata, exp_q[0][31:0]);
				void'(exp_q.pop_front());
			end
		end
	end

	// One APB transfer; held until pready is seen high at a rising edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No local limit: only the bench timeout ends a stuck access
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
		exp_q.push_back({err, e});
		xfer(1'b0, a, 32'h0);
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge pclk);
	endtask

	function automatic logic [7:0] gp_a(input int n, input logic [7:0] off);
		return 8'(tmw_pkg::GP_BASE + tmw_pkg::GP_STRIDE * 8'(n) + off);
	endfunction

	function automatic logic [7:0] wd_a(input int n, input logic [7:0] off);
		return 8'(tmw_pkg::WD_BASE + tmw_pkg::WD_STRIDE * 8'(n) + off);
	endfunction

	// Interval between two trigger pulses of timer n, bounded waits
	task automatic period(input int n, input int e);
		int t0;
		int k;
		cycles(1);
		k = 0;
		while (adc[n] !== 1'b1 && k < 300) begin cycles(1); k++; end
		t0 = cyc;
		cycles(1);
		k = 0;
		while (adc[n] !== 1'b1 && k < 300) begin cycles(1); k++; end
		chk(32'(cyc - t0), 32'(e));
	endtask

	initial begin
		void'($urandom(32'hfd60));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		ext_in[2:1] <= 2'($urandom);
		// Reset values, then an unmapped address
		rd(tmw_pkg::IRQ_STATUS, 32'h0);
		rd(tmw_pkg::IRQ_MASK, 32'h0);
		rd(tmw_pkg::OS_RELOAD, 32'h0);
		for (int n = 0; n < 3; n++) begin
			rd(gp_a(n, tmw_pkg::GP_CTRL_OFF), 32'h0);
			rd(gp_a(n, tmw_pkg::GP_RELOAD_OFF), 32'h0);
		end
		for (int n = 0; n < 2; n++) begin
			rd(wd_a(n, tmw_pkg::WD_CTRL_OFF), 32'h0);
			rd(wd_a(n, tmw_pkg::WD_LOAD_OFF), 32'hffff_ffff);
			rd(wd_a(n, tmw_pkg::WD_TIMEOUT_OFF), 32'h0);
		end
		rd(8'hf0, 32'h0, 1'b1);
		wr(gp_a(2, tmw_pkg::GP_RELOAD_OFF), 32'hffff_ffff);
		rd(gp_a(2, tmw_pkg::GP_RELOAD_OFF), 32'hffff_ffff);
		// Each timer on its own source code; wrong sources must not count
		for (int n = 0; n < 3; n++) begin
			r = 32'(3 + $urandom % 6);
			sel = 2'(n + 1);
			src_tick <= 4'hf & ~(4'h1 << sel);
			wr(gp_a(n, tmw_pkg::GP_RELOAD_OFF), r);
			wr(gp_a(n, tmw_pkg::GP_CTRL_OFF), {26'h0, sel, n != 1, 1'b1, n == 0, 1'b1});
			wr(gp_a(n, tmw_pkg::GP_COUNT_OFF), 32'h0);
			cycles(8);
			rd(gp_a(n, tmw_pkg::GP_COUNT_OFF), r);
			src_tick <= 4'h1 << sel;
			period(n, int'(r) + 1);
			wr(gp_a(n, tmw_pkg::GP_CTRL_OFF), 32'h0);
			cycles(3);
			chk(32'(syn_n[n]), (n == 1) ? 32'h0 : 32'(adc_n[n]));
			chk(32'(adc_n[n] > 1), 32'h1);
		end
		// Only the timer with its interrupt enabled flagged zero
		rd(tmw_pkg::IRQ_STATUS, 32'h01);
		chk(32'(irq), 32'h0);
		wr(tmw_pkg::IRQ_MASK, 32'h01);
		cycles(1);
		chk(32'(irq), 32'h1);
		wr(tmw_pkg::IRQ_STATUS, 32'h01);
		rd(tmw_pkg::IRQ_STATUS, 32'h0);
		cycles(1);
		chk(32'(irq), 32'h0);
		// External input as clock: four rising edges
		src_tick <= 4'h0;
		wr(gp_a(0, tmw_pkg::GP_RELOAD_OFF), 32'd10);
		wr(gp_a(0, tmw_pkg::GP_CTRL_OFF), 32'h49);
		wr(gp_a(0, tmw_pkg::GP_COUNT_OFF), 32'h0);
		repeat (4) begin
			ext_in[0] <= 1'b1;
			cycles(2);
			ext_in[0] <= 1'b0;
			cycles(2);
		end
		rd(gp_a(0, tmw_pkg::GP_COUNT_OFF), 32'd6);
		// External input as gate: three enabled ticks
		src_tick <= 4'h1;
		wr(gp_a(0, tmw_pkg::GP_CTRL_OFF), 32'h81);
		wr(gp_a(0, tmw_pkg::GP_COUNT_OFF), 32'h0);
		cycles(5);
		rd(gp_a(0, tmw_pkg::GP_COUNT_OFF), 32'd10);
		ext_in[0] <= 1'b1;
		cycles(3);
		ext_in[0] <= 1'b0;
		cycles(3);
		rd(gp_a(0, tmw_pkg::GP_COUNT_OFF), 32'd7);
		wr(gp_a(0, tmw_pkg::GP_CTRL_OFF), 32'h0);
		// OS tick: 24-bit reload, maskable zero flag
		wr(tmw_pkg::OS_RELOAD, 32'hffff_ffff);
		rd(tmw_pkg::OS_RELOAD, 32'h00ff_ffff);
		r = 32'(4 + $urandom % 8);
		wr(tmw_pkg::OS_RELOAD, r);
		wr(tmw_pkg::OS_CTRL, 32'h1);
		wr(tmw_pkg::OS_COUNT, 32'h0);
		cycles(int'(r) + 4);
		rd(tmw_pkg::IRQ_STATUS, 32'h20);
		chk(32'(irq), 32'h0);
		wr(tmw_pkg::IRQ_MASK, 32'h20);
		cycles(1);
		chk(32'(irq), 32'h1);
		wr(tmw_pkg::OS_CTRL, 32'h0);
		wr(tmw_pkg::IRQ_STATUS, 32'h20);
		rd(tmw_pkg::IRQ_STATUS, 32'h0);
		// Watchdogs in debug halt: one frozen, one running to time-out
		src_tick <= 4'hf;
		debug_halt <= 1'b1;
		for (int n = 0; n < 2; n++) begin
			wr(wd_a(n, tmw_pkg::WD_LOAD_OFF), 32'd8);
			wr(wd_a(n, tmw_pkg::WD_TIMEOUT_OFF), 32'(3 - n));
			wr(wd_a(n, tmw_pkg::WD_RESTART_OFF), 32'h0);
		end
		wr(wd_a(0, tmw_pkg::WD_CTRL_OFF), 32'h05);
		wr(wd_a(1, tmw_pkg::WD_CTRL_OFF), 32'h19);
		cycles(20);
		rd(wd_a(0, tmw_pkg::WD_RESTART_OFF), 32'd8);
		rd(wd_a(1, tmw_pkg::WD_RESTART_OFF), 32'd2);
		rd(tmw_pkg::IRQ_STATUS, 32'h10);
		// Timely restarts hold off the time-out, then it fires
		debug_halt <= 1'b0;
		repeat (6) wr(wd_a(0, tmw_pkg::WD_RESTART_OFF), 32'h0);
		rd(tmw_pkg::IRQ_STATUS, 32'h10);
		cycles(20);
		rd(tmw_pkg::IRQ_STATUS, 32'h18);
		// Reset mode: request instead of flag, cleared by restart
		wr(wd_a(0, tmw_pkg::WD_CTRL_OFF), 32'h0);
		wr(wd_a(1, tmw_pkg::WD_CTRL_OFF), 32'h1b);
		wr(tmw_pkg::IRQ_STATUS, 32'h18);
		wr(wd_a(1, tmw_pkg::WD_RESTART_OFF), 32'h0);
		cycles(20);
		chk(32'(wd_reset_req), 32'h1);
		rd(tmw_pkg::IRQ_STATUS, 32'h0);
		wr(wd_a(1, tmw_pkg::WD_CTRL_OFF), 32'h0);
		wr(wd_a(1, tmw_pkg::WD_RESTART_OFF), 32'h0);
		cycles(2);
		chk(32'(wd_reset_req), 32'h0);
		cycles(2);
		end_sim();
	end
endmodule // tmw_timers_tb
